// ==== common/ulcs_pkg.sv ====
// Summary of operation
// - Ident bit 0 low while interrupt pending
// - Ident bits 2:1 encode top pending type
// - Ident bit 3 marks FIFO timeout only
// - Ident bits 5:4 zero, 7:6 follow FIFO
// - Format bits 1:0 set data bits
// - Bit 2 sets transmit stop bits and receive timeout length
// - Bit 3 adds and checks parity bit
// - Bit 4 selects even, else odd
// - Bit 5 forces parity to inverse bit 4
// - Bit 6 holds serial output low
// - Bit 7 steers accesses to divisor bytes
// - Data ready set on receive, cleared by read
// - Overrun set on overwrite or full FIFO
// - Parity error per character, cleared by status read
// - Framing error on low first stop bit
// - Break seen after full low character
// - Line errors raise top priority interrupt
// - Holding empty set on transfer, cleared by write
// - Holding empty interrupt cleared by ident read
// - Transmitter empty when holding and shifter empty
// - FIFO error bit while errored characters remain
// - Priority: line, data/timeout, holding
package ulcs_pkg;
    localparam int ADR_W = 3;
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IER = 3'h1;
    localparam logic [2:0] ADR_IIR = 3'h2;
    localparam logic [2:0] ADR_LCR = 3'h3;
    localparam logic [2:0] ADR_LSR = 3'h5;
    localparam int LCR_STB = 2;
    localparam int LCR_PEN = 3;
    localparam int LCR_EPS = 4;
    localparam int LCR_STICK = 5;
    localparam int LCR_BRK = 6;
    localparam int LCR_DIVISOR_ACCESS_SELECT = 7;
    localparam int IER_RDA = 0;
    localparam int IER_HOLDING_EMPTY = 1;
    localparam int IER_RLS = 2;
    localparam int FCR_EN = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_RLS = 4'h6;
    localparam logic [3:0] IIR_RDA = 4'h4;
    localparam logic [3:0] IIR_TO = 4'hC;
    localparam logic [3:0] IIR_HOLDING_EMPTY = 4'h2;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [5:0] STOP_1 = 6'h0F;
    localparam logic [5:0] STOP_15 = 6'h17;
    localparam logic [5:0] STOP_2 = 6'h1F;
    localparam int FIFO_D = 16;
    localparam logic [4:0] FIFO_FULL = 5'h10;
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulcs_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} ulcs_rx_st_t;
endpackage

// ==== design/ulcs_tx.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulcs_tx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic load,
    input wire logic [7:0] data,
    input wire logic [1:0] wlen,
    input wire logic stop2,
    input wire logic pen,
    input wire logic eps,
    input wire logic stick,
    output logic busy,
    output logic line
);
    import ulcs_pkg::*;
    ulcs_tx_st_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [5:0] ct_q, ct_d;
    logic [2:0] bit_q, bit_d;
    logic line_q, line_d;
    logic par_q, par_d;
    logic [7:0] dm;
    logic [5:0] last;

    assign dm = data & (8'hFF >> (3'h3 - {1'b0, wlen}));
    // Half stop bit only exists for five-bit characters
    assign last = (st_q != TX_STOP) ? {2'b00, OVS_LAST} :
                  (!stop2 ? STOP_1 : (wlen == 2'b00 ? STOP_15 : STOP_2));
    assign busy = (st_q != TX_IDLE);
    assign line = line_q;

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        ct_d = ct_q;
        bit_d = bit_q;
        line_d = line_q;
        par_d = par_q;
        case (st_q)
            TX_IDLE: begin
                if (load) begin
                    sh_d = dm;
                    par_d = stick ? !eps : (eps ? ^dm : !(^dm));
                    st_d = TX_START;
                    ct_d = '0;
                    bit_d = '0;
                    line_d = 1'b0;
                end
            end
            default: begin
                if (tick) begin
                    ct_d = ct_q + 6'h01;
                    if (ct_q == last) begin
                        ct_d = '0;
                        case (st_q)
                            TX_START: begin
                                st_d = TX_DATA;
                                line_d = sh_q[0];
                            end
                            TX_DATA: begin
                                sh_d = sh_q >> 1;
                                bit_d = bit_q + 3'h1;
                                line_d = sh_q[1];
                                if (bit_q == {1'b1, wlen}) begin
                                    st_d = pen ? TX_PAR : TX_STOP;
                                    line_d = pen ? par_q : 1'b1;
                                end
                            end
                            TX_PAR: begin
                                st_d = TX_STOP;
                                line_d = 1'b1;
                            end
                            default: st_d = TX_IDLE;
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= TX_IDLE;
            sh_q <= '0;
            ct_q <= '0;
            bit_q <= '0;
            line_q <= 1'b1;
            par_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            ct_q <= ct_d;
            bit_q <= bit_d;
            line_q <= line_d;
            par_q <= par_d;
        end
    end
endmodule
`default_nettype wire

// ==== design/ulcs_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulcs_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ulcs_pkg::ADR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic serial_in,
    output logic serial_out,
    output logic irq_out
);
    import ulcs_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] lcr_q, lcr_d;
    logic [3:0] ier_q, ier_d;
    logic [7:0] dll_q, dll_d;
    logic [7:0] dlh_q, dlh_d;
    logic fen_q, fen_d;
    logic [1:0] trig_q, trig_d;
    logic [15:0] dct_q, dct_d;
    logic tick;
    logic divisor_access_select, wr_thr, wr_dll, wr_dlh, wr_ier, wr_fcr, wr_lcr;
    logic rd_rbr, rd_iir, rd_lsr;
    logic [1:0] wlen;
    logic pen, eps, stick, stop2;

    assign divisor_access_select = lcr_q[LCR_DIVISOR_ACCESS_SELECT];
    assign wlen = lcr_q[1:0];
    assign stop2 = lcr_q[LCR_STB];
    assign pen = lcr_q[LCR_PEN];
    assign eps = lcr_q[LCR_EPS];
    assign stick = lcr_q[LCR_STICK];
    // Divisor latch shares offsets with data and enable registers
    assign wr_thr = wr_stb && addr == ADR_DATA && !divisor_access_select;
    assign wr_dll = wr_stb && addr == ADR_DATA && divisor_access_select;
    assign wr_ier = wr_stb && addr == ADR_IER && !divisor_access_select;
    assign wr_dlh = wr_stb && addr == ADR_IER && divisor_access_select;
    assign wr_fcr = wr_stb && addr == ADR_IIR;
    assign wr_lcr = wr_stb && addr == ADR_LCR;
    assign rd_rbr = rd_stb && addr == ADR_DATA && !divisor_access_select;
    assign rd_iir = rd_stb && addr == ADR_IIR;
    assign rd_lsr = rd_stb && addr == ADR_LSR;

    // Control registers
    always_comb begin
        lcr_d = wr_lcr ? wr_data : lcr_q;
        ier_d = wr_ier ? wr_data[3:0] : ier_q;
        dll_d = wr_dll ? wr_data : dll_q;
        dlh_d = wr_dlh ? wr_data : dlh_q;
        fen_d = wr_fcr ? wr_data[FCR_EN] : fen_q;
        trig_d = wr_fcr ? wr_data[7:6] : trig_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lcr_q <= LCR_RST;
            ier_q <= '0;
            dll_q <= DIV_RST[7:0];
            dlh_q <= DIV_RST[15:8];
            fen_q <= 1'b0;
            trig_q <= '0;
        end else begin
            lcr_q <= lcr_d;
            ier_q <= ier_d;
            dll_q <= dll_d;
            dlh_q <= dlh_d;
            fen_q <= fen_d;
            trig_q <= trig_d;
        end
    end

    // 16x bit-rate enable; a divisor write reloads at once
    assign tick = (dct_q == 16'h0001);
    always_comb begin
        dct_d = dct_q - 16'h0001;
        if (wr_dll || wr_dlh || tick || dct_q == 16'h0000) begin
            dct_d = {dlh_d, dll_d};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dct_q <= DIV_RST;
        end else begin
            dct_q <= dct_d;
        end
    end

    // Receiver
    ulcs_rx_st_t rx_st_q, rx_st_d;
    logic [3:0] rx_ct_q, rx_ct_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic rx_par_q, rx_par_d, rx_zero_q, rx_zero_d, rx_pe_q, rx_pe_d;
    logic rx_push;
    logic [10:0] rx_word;

    always_comb begin
        rx_st_d = rx_st_q;
        rx_ct_d = rx_ct_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_par_d = rx_par_q;
        rx_zero_d = rx_zero_q;
        rx_pe_d = rx_pe_q;
        rx_push = 1'b0;
        rx_word = '0;
        if (tick) begin
            rx_ct_d = rx_ct_q + 4'h1;
            case (rx_st_q)
                RX_IDLE: begin
                    rx_ct_d = '0;
                    if (!serial_in) begin
                        rx_st_d = RX_START;
                    end
                end
                RX_START: if (rx_ct_q == OVS_MID) begin
                    // High at mid start bit is a false start
                    rx_ct_d = '0;
                    rx_bit_d = '0;
                    rx_par_d = 1'b0;
                    rx_pe_d = 1'b0;
                    rx_zero_d = 1'b1;
                    rx_st_d = serial_in ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_ct_q == OVS_LAST) begin
                    rx_sh_d = {serial_in, rx_sh_q[7:1]};
                    rx_par_d = rx_par_q ^ serial_in;
                    rx_zero_d = rx_zero_q & !serial_in;
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == {1'b1, wlen}) begin
                        rx_st_d = pen ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (rx_ct_q == OVS_LAST) begin
                    rx_pe_d = stick ? (serial_in == eps) :
                              (eps ? rx_par_q ^ serial_in : !(rx_par_q ^ serial_in));
                    rx_zero_d = rx_zero_q & !serial_in;
                    rx_st_d = RX_STOP;
                end
                RX_STOP: if (rx_ct_q == OVS_LAST) begin
                    // Only the first stop bit is looked at
                    rx_push = 1'b1;
                    rx_word = {rx_zero_q & !serial_in, !serial_in, rx_pe_q,
                               rx_sh_q >> (3'h3 - {1'b0, wlen})};
                    rx_st_d = (rx_zero_q && !serial_in) ? RX_BRK : RX_IDLE;
                end
                RX_BRK: begin
                    if (serial_in) begin
                        rx_st_d = RX_IDLE;
                    end
                end
                default: rx_st_d = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_st_q <= RX_IDLE;
            rx_ct_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            rx_par_q <= 1'b0;
            rx_zero_q <= 1'b0;
            rx_pe_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rx_ct_q <= rx_ct_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_par_q <= rx_par_d;
            rx_zero_q <= rx_zero_d;
            rx_pe_q <= rx_pe_d;
        end
    end

    // Receive buffer: one slot without FIFO mode, sixteen with it
    logic [10:0] rx_mem [FIFO_D];
    logic [3:0] rx_rd_q, rx_rd_d, rx_wr_q, rx_wr_d, rx_wa;
    logic [4:0] rx_cnt_q, rx_cnt_d, trig_lvl;
    logic oe_q, oe_d, rx_we, rx_pop, ovw, drop, rx_flush;
    logic [2:0] err_q, err_d, head_err;
    logic [9:0] to_q, to_d, to_lim;
    logic [3:0] chr_bits;
    logic [15:0] ent_err;
    logic err_any, to_hit;

    for (genvar gi = 0; gi < FIFO_D; gi++) begin : g_err
        logic [3:0] ofs;
        assign ofs = 4'(gi) - rx_rd_q;
        assign ent_err[gi] = ({1'b0, ofs} < rx_cnt_q) && (|rx_mem[gi][10:8]);
    end
    assign err_any = |ent_err;

    // Timer counts four character times, second stop bit included
    assign chr_bits = 4'h7 + {2'b00, wlen} + {3'b000, pen} + {3'b000, stop2};
    assign to_lim = {chr_bits, 6'h00};
    assign to_hit = (to_q == to_lim) && rx_cnt_q != 5'h00;

    always_comb begin
        case (trig_q)
            2'b00: trig_lvl = TRIG_L0;
            2'b01: trig_lvl = TRIG_L1;
            2'b10: trig_lvl = TRIG_L2;
            default: trig_lvl = TRIG_L3;
        endcase
    end

    always_comb begin
        rx_flush = wr_fcr && (wr_data[FCR_EN] != fen_q || wr_data[FCR_RXCLR]);
        rx_pop = rd_rbr && rx_cnt_q != 5'h00;
        ovw = rx_push && !fen_q && rx_cnt_q != 5'h00 && !rx_pop;
        drop = rx_push && fen_q && rx_cnt_q == FIFO_FULL && !rx_pop;
        rx_we = rx_push && !drop;
        rx_wa = ovw ? rx_rd_q : rx_wr_q;
        rx_rd_d = rx_rd_q + {3'b000, rx_pop};
        rx_wr_d = rx_wr_q + {3'b000, rx_we && !ovw};
        rx_cnt_d = rx_cnt_q + {4'h0, rx_we && !ovw} - {4'h0, rx_pop};
        // Error bits follow their character to the head
        head_err = 3'b000;
        if (rx_we && (rx_cnt_q == 5'h00 || ovw || (rx_pop && rx_cnt_q == 5'h01))) begin
            head_err = rx_word[10:8];
        end else if (rx_pop && rx_cnt_q > 5'h01) begin
            head_err = rx_mem[rx_rd_q + 4'h1][10:8];
        end
        // A new event in a status read cycle survives the clear
        oe_d = (rd_lsr ? 1'b0 : oe_q) | ovw | drop;
        err_d = (rd_lsr ? 3'b000 : err_q) | head_err;
        to_d = to_q;
        if (rx_push || rx_pop || rx_cnt_q == 5'h00 || !fen_q) begin
            to_d = '0;
        end else if (tick && to_q != to_lim) begin
            to_d = to_q + 10'h001;
        end
        if (rx_flush) begin
            rx_rd_d = '0;
            rx_wr_d = '0;
            rx_cnt_d = '0;
            err_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rx_we) begin
            rx_mem[rx_wa] <= rx_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_rd_q <= '0;
            rx_wr_q <= '0;
            rx_cnt_q <= '0;
            oe_q <= 1'b0;
            err_q <= '0;
            to_q <= '0;
        end else begin
            rx_rd_q <= rx_rd_d;
            rx_wr_q <= rx_wr_d;
            rx_cnt_q <= rx_cnt_d;
            oe_q <= oe_d;
            err_q <= err_d;
            to_q <= to_d;
        end
    end

    // Transmit holding: one slot without FIFO mode, sixteen with it
    logic [7:0] tx_mem [FIFO_D];
    logic [3:0] tx_rd_q, tx_rd_d, tx_wr_q, tx_wr_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic holding_empty_q, holding_empty_d, tx_we, tx_load, tx_busy, tx_line, tx_flush;
    logic holding_empty_set, holding_empty_clr, hold_empty, tx_empty;
    logic [3:0] iir_code;

    assign hold_empty = (tx_cnt_q == 5'h00);
    assign tx_empty = hold_empty && !tx_busy;

    always_comb begin
        tx_flush = wr_fcr && (wr_data[FCR_EN] != fen_q || wr_data[FCR_TXCLR]);
        // Writes to a full holding stage are dropped
        tx_we = wr_thr && (fen_q ? tx_cnt_q != FIFO_FULL : tx_cnt_q == 5'h00);
        tx_load = !hold_empty && !tx_busy;
        tx_rd_d = tx_rd_q + {3'b000, tx_load};
        tx_wr_d = tx_wr_q + {3'b000, tx_we};
        tx_cnt_d = tx_cnt_q + {4'h0, tx_we} - {4'h0, tx_load};
        if (tx_flush) begin
            tx_rd_d = '0;
            tx_wr_d = '0;
            tx_cnt_d = '0;
        end
        holding_empty_set = (!hold_empty && tx_cnt_d == 5'h00) ||
                   (wr_ier && wr_data[IER_HOLDING_EMPTY] && !ier_q[IER_HOLDING_EMPTY] && hold_empty);
        holding_empty_clr = wr_thr || (rd_iir && iir_code == IIR_HOLDING_EMPTY);
        holding_empty_d = (holding_empty_clr ? 1'b0 : holding_empty_q) | holding_empty_set;
    end

    always_ff @(posedge clk) begin
        if (tx_we) begin
            tx_mem[tx_wr_q] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_rd_q <= '0;
            tx_wr_q <= '0;
            tx_cnt_q <= '0;
            holding_empty_q <= 1'b0;
        end else begin
            tx_rd_q <= tx_rd_d;
            tx_wr_q <= tx_wr_d;
            tx_cnt_q <= tx_cnt_d;
            holding_empty_q <= holding_empty_d;
        end
    end

    ulcs_tx u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .load(tx_load),
        .data(tx_mem[tx_rd_q]),
        .wlen(wlen),
        .stop2(stop2),
        .pen(pen),
        .eps(eps),
        .stick(stick),
        .busy(tx_busy),
        .line(tx_line)
    );

    // Interrupt identification and read port
    logic [7:0] interrupt_ident, line_status, rd_q, rd_d;
    logic sout_q, sout_d, irq_q, irq_d, rls_src;

    assign rls_src = oe_q || (|err_q);
    always_comb begin
        if (ier_q[IER_RLS] && rls_src) begin
            iir_code = IIR_RLS;
        end else if (ier_q[IER_RDA] && (fen_q ? rx_cnt_q >= trig_lvl : rx_cnt_q != 5'h00)) begin
            iir_code = IIR_RDA;
        end else if (ier_q[IER_RDA] && fen_q && to_hit) begin
            iir_code = IIR_TO;
        end else if (ier_q[IER_HOLDING_EMPTY] && holding_empty_q) begin
            iir_code = IIR_HOLDING_EMPTY;
        end else begin
            iir_code = IIR_NONE;
        end
    end
    assign interrupt_ident = {{2{fen_q}}, 2'b00, iir_code};
    assign line_status = {fen_q && err_any, tx_empty, hold_empty, err_q, oe_q,
                  rx_cnt_q != 5'h00};

    always_comb begin
        rd_d = 8'h00;
        if (rd_stb) begin
            case (addr)
                ADR_DATA: rd_d = divisor_access_select ? dll_q : rx_mem[rx_rd_q][7:0];
                ADR_IER: rd_d = divisor_access_select ? dlh_q : {4'h0, ier_q};
                ADR_IIR: rd_d = interrupt_ident;
                ADR_LCR: rd_d = lcr_q;
                ADR_LSR: rd_d = line_status;
                default: rd_d = 8'h00;
            endcase
        end
        sout_d = lcr_q[LCR_BRK] ? 1'b0 : tx_line;
        irq_d = (iir_code != IIR_NONE);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q <= '0;
            sout_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            sout_q <= sout_d;
            irq_q <= irq_d;
        end
    end
    assign rd_data = rd_q;
    assign serial_out = sout_q;
    assign irq_out = irq_q;

    property p_iir_pend;
        rd_iir |=> rd_data[0] == ($past(iir_code) == IIR_NONE);
    endproperty
    a_iir_pend: assert property (p_iir_pend) else $error("ident bit 0 wrong");
    property p_iir_rls;
        rd_iir && ier_q[IER_RLS] && rls_src |=> rd_data[3:0] == IIR_RLS;
    endproperty
    a_iir_rls: assert property (p_iir_rls) else $error("line status not top");
    property p_iir_b3;
        rd_iir && !fen_q |=> !rd_data[3];
    endproperty
    a_iir_b3: assert property (p_iir_b3) else $error("ident bit 3 set");
    property p_iir_hi;
        rd_iir |=> rd_data[5:4] == 2'b00 && rd_data[7:6] == {2{$past(fen_q)}};
    endproperty
    a_iir_hi: assert property (p_iir_hi) else $error("ident high bits");
    property p_brk;
        lcr_q[LCR_BRK] |=> !serial_out;
    endproperty
    a_brk: assert property (p_brk) else $error("break not low");
    property p_ovr;
        rx_push && !rx_pop && (fen_q ? rx_cnt_q == FIFO_FULL : rx_cnt_q != 5'h00)
            |=> oe_q && $stable(rx_cnt_q);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");
    property p_lsr_clr;
        rd_lsr && !rx_push |=> !oe_q && err_q == 3'b000;
    endproperty
    a_lsr_clr: assert property (p_lsr_clr) else $error("status read no clear");
    property p_transmitter_empty;
        wr_thr && hold_empty && !tx_flush |=> !tx_empty [*2];
    endproperty
    a_transmitter_empty: assert property (p_transmitter_empty) else $error("tx empty after write");
    property p_holding_empty_keep;
        rd_lsr && !wr_thr && !rd_iir |=> holding_empty_q || !$past(holding_empty_q);
    endproperty
    a_holding_empty_keep: assert property (p_holding_empty_keep) else $error("status read hit holding_empty");
    property p_holding_empty_iir;
        rd_iir && iir_code == IIR_HOLDING_EMPTY && !holding_empty_set |=> !holding_empty_q;
    endproperty
    a_holding_empty_iir: assert property (p_holding_empty_iir) else $error("holding_empty not cleared");
    property p_dr;
        rd_rbr && rx_cnt_q == 5'h01 && !rx_push |=> rx_cnt_q == 5'h00;
    endproperty
    a_dr: assert property (p_dr) else $error("data ready stuck");

    c_brk: cover property (rx_push && rx_word[10]);
    c_to: cover property (iir_code == IIR_TO);
    c_ovr: cover property (drop);
endmodule
`default_nettype wire

// ==== test/ulcs_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulcs_peer (
    input wire logic clk,
    input wire logic serial_out,
    output logic serial_in
);
    initial serial_in = 1'b1;
    // Start low, then ten slots LSB first, 16 clocks each at divisor 1
    task automatic send(input logic [9:0] f);
        int i;
        @(posedge clk) serial_in <= 1'b0;
        repeat (16) @(posedge clk);
        for (i = 0; i < 10; i++) begin
            serial_in <= f[i];
            repeat (16) @(posedge clk);
        end
        serial_in <= 1'b1;
    endtask
    // Samples mid-slot; slots past the frame must read idle high
    task automatic take(output logic [9:0] d);
        int i;
        @(negedge serial_out);
        repeat (8) @(posedge clk);
        for (i = 0; i < 10; i++) begin
            repeat (16) @(posedge clk);
            d[i] = serial_out;
        end
    endtask
endmodule
`default_nettype wire

// ==== test/ulcs_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module ulcs_top_test;
    import ulcs_pkg::*;
    logic clk, rst_n, wr_stb, rd_stb, serial_in, serial_out, irq_out;
    logic [ADR_W-1:0] addr;
    logic [7:0] wr_data, rd_data, v;
    logic [9:0] got;
    logic [25:0] tab [8];
    int mismatches, cmp_count, i;
    ulcs_top dut(.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .serial_in(serial_in), .serial_out(serial_out),
        .irq_out(irq_out));
    ulcs_peer peer(.clk(clk), .serial_out(serial_out), .serial_in(serial_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk) wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk) rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk({2'h0, d}, {2'h0, e});
    endtask
    task automatic complete_run;
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        complete_run;
    end
    initial begin
        tab = '{{8'h03, 8'hA5, 10'h3A5}, {8'h02, 8'h5A, 10'h3DA}, {8'h1B, 8'hA5, 10'h2A5},
            {8'h0B, 8'hA5, 10'h3A5}, {8'h3B, 8'hA5, 10'h2A5}, {8'h2B, 8'hA5, 10'h3A5},
            {8'h00, 8'h15, 10'h3F5}, {8'h01, 8'h2A, 10'h3EA}};
        rst_n = 1'b0;
        addr = '0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rc(ADR_LCR, 8'h00);
        rc(ADR_IIR, 8'h01);
        rc(ADR_LSR, 8'h60);
        for (i = 0; i < 8; i++) begin
            wr(ADR_LCR, tab[i][25:18]);
            fork
                peer.take(got);
                begin
                    wr(ADR_DATA, tab[i][17:10]);
                    rd(ADR_LSR, v);
                end
            join
            chk({2'h0, v & 8'h40}, 10'h000);
            chk(got, tab[i][9:0]);
            repeat (40) @(posedge clk);
        end
        rc(ADR_LSR, 8'h60);
        wr(ADR_LCR, 8'h43);
        repeat (3) @(posedge clk);
        chk({9'h0, serial_out}, 10'h000);
        wr(ADR_LCR, 8'h83);
        wr(ADR_DATA, 8'h02);
        rc(ADR_DATA, 8'h02);
        wr(ADR_DATA, 8'h01);
        wr(ADR_LCR, 8'h03);
        chk({9'h0, serial_out}, 10'h001);
        wr(ADR_LSR, 8'hFF);
        rc(ADR_LSR, 8'h60);
        rc(3'h7, 8'h00);
        peer.send(10'h33C);
        rc(ADR_LSR, 8'h61);
        rc(ADR_DATA, 8'h3C);
        rc(ADR_LSR, 8'h60);
        peer.send(10'h33C);
        peer.send(10'h35A);
        rc(ADR_LSR, 8'h63);
        rc(ADR_DATA, 8'h5A);
        rc(ADR_LSR, 8'h60);
        wr(ADR_LCR, 8'h1B);
        wr(ADR_IER, 8'h06);
        peer.send(10'h3A5);
        rc(ADR_IIR, 8'h06);
        chk({9'h0, irq_out}, 10'h001);
        rc(ADR_LSR, 8'h65);
        rc(ADR_IIR, 8'h02);
        rc(ADR_IIR, 8'h01);
        rd(ADR_DATA, v);
        wr(ADR_LCR, 8'h03);
        peer.send(10'h23C);
        rc(ADR_LSR, 8'h69);
        rd(ADR_DATA, v);
        peer.send(10'h000);
        rd(ADR_LSR, v);
        chk({2'h0, v & 8'h10}, 10'h010);
        rd(ADR_DATA, v);
        rc(ADR_LSR, 8'h60);
        // Trigger of four keeps a lone character below the data interrupt
        wr(ADR_IER, 8'h01);
        wr(ADR_IIR, 8'h41);
        rc(ADR_IIR, 8'hC1);
        peer.send(10'h23C);
        rc(ADR_LSR, 8'hE9);
        rc(ADR_LSR, 8'hE1);
        rc(ADR_IIR, 8'hC1);
        repeat (700) @(posedge clk);
        rc(ADR_IIR, 8'hCC);
        rc(ADR_DATA, 8'h3C);
        rc(ADR_LSR, 8'h60);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk({8'h00, irq_out, serial_out}, 10'h001);
        rc(ADR_IIR, 8'h01);
        complete_run;
    end
endmodule
`default_nettype wire
